// ---- shared/ppl_pkg.sv ----
`default_nettype none
package ppl_pkg;
    localparam int CLK_NS          = 50;
    // programmer timing, in ns
    localparam int SETUP_NS        = 200;
    localparam int PULSE_NS        = 500;
    localparam int RECOVER_NS      = 500;
    localparam int VERIFY_NS       = 500;
    localparam int EXP_RECOVER_NS  = 60000;
    // device commit time of an expanded write, in ns
    localparam int EXP_BUSY_NS     = 50000;
    localparam int SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC       = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_CYC     = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int VERIFY_CYC      = (VERIFY_NS + CLK_NS - 1) / CLK_NS;
    localparam int EXP_RECOVER_CYC = (EXP_RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int EXP_BUSY_CYC    = (EXP_BUSY_NS + CLK_NS - 1) / CLK_NS;
    // memory sizes
    localparam int MEM_BYTES       = 32768;
    localparam int NORM_BYTES      = 4096;
    localparam int KEY_COUNT       = 5;
    // configuration register map (port 1 address, port 2 zero)
    localparam logic [7:0] MEMORY_CONFIG_REG_ADDR   = 8'hC6;
    localparam logic [7:0] KEY_BASE    = 8'hC0;
    localparam int         LOCK_BIT    = 0;
    localparam int         RANGE_BIT   = 3;
    localparam int         PART_LSB    = 4;
    localparam logic [7:0] MEMORY_CONFIG_REG_RESET  = 8'h00;
    // range 8K (bit clear), partition at 4K
    localparam logic [7:0] MEMORY_CONFIG_REG_INIT   = 8'h10;
    // controller registers
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_ADDR    = 4'h1;
    localparam logic [3:0] REG_DATA    = 4'h2;
    localparam logic [3:0] REG_STATUS  = 4'h3;
    localparam int         CTRL_EN_BIT = 0;
    localparam int         CTRL_OP_LSB = 1;
    localparam int         CTRL_GO_BIT = 4;
    localparam logic [2:0] MODE_IDLE   = 3'h7;
    typedef enum logic [2:0] {
        PPL_OP_PROG, PPL_OP_SECURE, PPL_OP_VERIFY, PPL_OP_PROG_EXP,
        PPL_OP_VERIFY_EXP, PPL_OP_PROG_CFG, PPL_OP_VERIFY_CFG
    } ppl_op_t;
endpackage
`default_nettype wire

// ---- shared/ppl_link_if.sv ----
`default_nettype none
interface ppl_link_if;
    logic       reset_pin;
    logic       program_fetch_strobe_n;
    logic       prog_pulse_n;
    logic       external_access_pin;
    logic       external_access_pin_hv;
    logic       mode_select_hi;
    logic       mode_select_mid;
    logic       mode_select_lo;
    logic [7:0] port1_addr;
    logic [6:0] port2_addr;
    logic [7:0] prog_data_out;
    logic       prog_data_oe;
    logic [7:0] dev_data_out;
    logic       dev_data_oe;
    logic [7:0] port0_level;
    // pulled-up data port
    assign port0_level = dev_data_oe ? dev_data_out : (prog_data_oe ? prog_data_out : 8'hFF);
    modport dev (
        input  reset_pin, program_fetch_strobe_n, prog_pulse_n, external_access_pin,
        input  external_access_pin_hv, mode_select_hi, mode_select_mid, mode_select_lo,
        input  port1_addr, port2_addr, port0_level,
        output dev_data_out, dev_data_oe
    );
    modport prog (
        output reset_pin, program_fetch_strobe_n, prog_pulse_n, external_access_pin,
        output external_access_pin_hv, mode_select_hi, mode_select_mid, mode_select_lo,
        output port1_addr, port2_addr, prog_data_out, prog_data_oe,
        input  port0_level
    );
endinterface
`default_nettype wire

// ---- core/ppl_device.sv ----
// Overview of operation
// - programmer enters load mode: reset high, strobe low
// - program cycle writes one byte
// - verify cycle returns stored byte
// - security set cycle engages lock
// - expanded cycles reach 32K bytes
// - config cycles write config/keys, read config
// - config address on port 1, port 2 zero
// - first normal program or security strobe sets default memory map
// - programmer waits longer after expanded program cycles
// - lock on security cycle or config bit 0
// - program, keys, config, verify, then lock
`default_nettype none
module ppl_device #(
    parameter int MEM_BYTES    = ppl_pkg::MEM_BYTES,
    parameter int NORM_BYTES   = ppl_pkg::NORM_BYTES,
    parameter int EXP_BUSY_CYC = ppl_pkg::EXP_BUSY_CYC
) (
    input  wire logic                             clock,
    input  wire logic                             resetn,
    ppl_link_if.dev                               link,
    output logic [7:0]                            memory_config_reg_o,
    output logic [8*ppl_pkg::KEY_COUNT-1:0]       key_o,
    output logic                                  lock_o,
    output logic                                  busy_o
);
    localparam int MEM_AW  = $clog2(MEM_BYTES);
    localparam int NORM_AW = $clog2(NORM_BYTES);
    localparam int CNT_W   = $clog2(EXP_BUSY_CYC + 1);
    localparam int SYNC_W  = 31;

    if (MEM_BYTES > 32768 || NORM_BYTES > MEM_BYTES || (1 << MEM_AW) != MEM_BYTES ||
        (1 << NORM_AW) != NORM_BYTES || EXP_BUSY_CYC < 1) begin : g_bad_param
        $error("ppl_device: unsupported memory size or busy count");
    end

    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              pulse_prev_r;
    logic [7:0]        memory_config_reg_r;
    logic [7:0]        key_r [ppl_pkg::KEY_COUNT];
    logic              init_done_r;
    logic [CNT_W-1:0]  busy_cnt_r;
    logic              busy_r;
    logic [MEM_AW-1:0] pend_addr_r;
    logic [7:0]        pend_data_r;
    logic [7:0]        mem_r [MEM_BYTES];
    logic [7:0]        rd_data_r;
    logic              rd_oe_r;

    // pins come from another chip: two flops first
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {link.reset_pin, link.program_fetch_strobe_n, link.prog_pulse_n,
                        link.external_access_pin, link.external_access_pin_hv,
                        link.mode_select_hi, link.mode_select_mid, link.mode_select_lo,
                        link.port2_addr, link.port1_addr, link.port0_level};
            sync2_r <= sync1_r;
        end
    end

    logic        s_rst;
    logic        s_fetch_n;
    logic        s_pulse_n;
    logic        s_ea;
    logic        s_hv;
    logic        s_hi;
    logic        s_mid;
    logic        s_lo;
    logic [6:0]  s_p2;
    logic [7:0]  s_p1;
    logic [7:0]  s_data;
    assign {s_rst, s_fetch_n, s_pulse_n, s_ea, s_hv, s_hi, s_mid, s_lo, s_p2, s_p1, s_data} = sync2_r;

    logic              load_mode;
    logic              strobe;
    logic              cyc_prog;
    logic              cyc_sec;
    logic              cyc_pexp;
    logic              cyc_pcfg;
    logic              rd_norm;
    logic              rd_exp;
    logic              rd_cfg;
    logic              cfg_port_ok;
    logic              busy;
    logic [MEM_AW-1:0] norm_idx;
    logic [MEM_AW-1:0] exp_idx;

    assign busy = busy_r;
    assign load_mode = s_rst & ~s_fetch_n;
    // falling edge of the program pulse under high voltage; ignored while an expanded write settles
    assign strobe    = pulse_prev_r & ~s_pulse_n & load_mode & s_hv & ~busy;
    assign cyc_prog  = strobe & s_hi & ~s_mid;
    assign cyc_sec   = strobe & s_hi & s_mid;
    assign cyc_pexp  = strobe & ~s_hi & s_mid & ~s_lo;
    assign cyc_pcfg  = strobe & ~s_hi & s_mid & s_lo;
    assign rd_norm   = s_rst & s_ea & ~s_hv & ~s_hi & ~s_mid;
    assign rd_exp    = load_mode & s_pulse_n & s_ea & ~s_hv & ~s_hi & s_mid & ~s_lo;
    assign rd_cfg    = load_mode & s_pulse_n & s_ea & ~s_hv & ~s_hi & s_mid & s_lo;
    // config address needs port 2 at zero
    assign cfg_port_ok = (s_p2 == 7'h00);
    assign norm_idx  = MEM_AW'(s_p1) | (MEM_AW'(s_p2) << 8) & MEM_AW'(NORM_BYTES - 1);
    assign exp_idx   = MEM_AW'({s_p2, s_p1});

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // matches the synchroniser reset value, so no false edge after reset
            pulse_prev_r <= 1'b0;
        end else begin
            pulse_prev_r <= s_pulse_n;
        end
    end

    // expanded writes commit late, modelling the slow path
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_r  <= '0;
            busy_r      <= 1'b0;
            pend_addr_r <= '0;
            pend_data_r <= 8'h00;
        end else if (cyc_pexp) begin
            busy_cnt_r  <= CNT_W'(EXP_BUSY_CYC);
            busy_r      <= 1'b1;
            pend_addr_r <= exp_idx;
            pend_data_r <= s_data;
        end else if (busy) begin
            busy_cnt_r  <= busy_cnt_r - CNT_W'(1);
            busy_r      <= (busy_cnt_r != CNT_W'(1));
        end
    end

    // nonvolatile contents: no reset on purpose
    always_ff @(posedge clock) begin
        // normal byte write, low bank only
        if (cyc_prog) begin
            mem_r[norm_idx] <= s_data;
        end
        if (busy_cnt_r == CNT_W'(1)) begin
            mem_r[pend_addr_r] <= pend_data_r;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            memory_config_reg_r      <= ppl_pkg::MEMORY_CONFIG_REG_RESET;
            init_done_r <= 1'b0;
        end else if (cyc_pcfg && cfg_port_ok && s_p1 == ppl_pkg::MEMORY_CONFIG_REG_ADDR) begin
            memory_config_reg_r <= s_data;
        end else if (cyc_prog || cyc_sec) begin
            init_done_r <= 1'b1;
            if (!init_done_r) begin
                memory_config_reg_r <= ppl_pkg::MEMORY_CONFIG_REG_INIT;
            end
            if (cyc_sec) begin
                memory_config_reg_r[ppl_pkg::LOCK_BIT] <= 1'b1;
            end
        end
    end

    for (genvar k = 0; k < ppl_pkg::KEY_COUNT; k++) begin : g_key
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                key_r[k] <= 8'h00;
            end else if (cyc_pcfg && cfg_port_ok && s_p1 == ppl_pkg::KEY_BASE + 8'(k)) begin
                key_r[k] <= s_data;
            end
        end
        assign key_o[8*k +: 8] = key_r[k];
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_data_r <= 8'h00;
            rd_oe_r   <= 1'b0;
        end else begin
            rd_oe_r <= rd_norm | rd_exp | rd_cfg;
            if (rd_norm) begin
                rd_data_r <= mem_r[norm_idx];
            end else if (rd_exp) begin
                rd_data_r <= mem_r[exp_idx];
            end else if (rd_cfg) begin
                rd_data_r <= memory_config_reg_r;
            end else begin
                rd_data_r <= 8'h00;
            end
        end
    end

    assign link.dev_data_out = rd_data_r;
    assign link.dev_data_oe  = rd_oe_r;
    assign memory_config_reg_o            = memory_config_reg_r;
    assign lock_o            = memory_config_reg_r[ppl_pkg::LOCK_BIT];
    assign busy_o            = busy_r;
endmodule
`default_nettype wire

// ---- core/ppl_programmer.sv ----
// The address map and the strobed register port were left to the implementer.
`default_nettype none
module ppl_programmer #(
    parameter int SETUP_CYC       = ppl_pkg::SETUP_CYC,
    parameter int PULSE_CYC       = ppl_pkg::PULSE_CYC,
    parameter int RECOVER_CYC     = ppl_pkg::RECOVER_CYC,
    parameter int VERIFY_CYC      = ppl_pkg::VERIFY_CYC,
    parameter int EXP_RECOVER_CYC = ppl_pkg::EXP_RECOVER_CYC
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    ppl_link_if.prog         link,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata
);
    localparam int CNT_W = 12;
    if (SETUP_CYC < 1 || PULSE_CYC < 1 || RECOVER_CYC < 1 || VERIFY_CYC < 4 ||
        EXP_RECOVER_CYC < 1 || EXP_RECOVER_CYC > 4095) begin : g_bad_param
        $error("ppl_programmer: timing count out of range");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} ppl_state_t;

    ppl_state_t        state_r;
    logic [CNT_W-1:0]  cnt_r;
    logic              en_r;
    ppl_pkg::ppl_op_t  op_r;
    ppl_pkg::ppl_op_t  ctrl_op_r;
    logic [14:0]       addr_r;
    logic [7:0]        data_r;
    logic [7:0]        rd_byte_r;
    logic              done_r;
    logic [7:0]        din1_r;
    logic [7:0]        din2_r;
    logic [15:0]       rdata_r;
    logic              pulse_n_r;
    logic              hv_r;
    logic [2:0]        mode_r;
    logic [14:0]       pin_addr_r;
    logic [7:0]        dout_r;
    logic              doe_r;
    logic              go;
    logic              is_write;

    function automatic logic [2:0] mode_of(input ppl_pkg::ppl_op_t op);
        case (op)
            ppl_pkg::PPL_OP_PROG:       mode_of = 3'h4;
            ppl_pkg::PPL_OP_SECURE:     mode_of = 3'h6;
            ppl_pkg::PPL_OP_VERIFY:     mode_of = 3'h0;
            ppl_pkg::PPL_OP_PROG_EXP,
            ppl_pkg::PPL_OP_VERIFY_EXP: mode_of = 3'h2;
            ppl_pkg::PPL_OP_PROG_CFG,
            ppl_pkg::PPL_OP_VERIFY_CFG: mode_of = 3'h3;
            default:                    mode_of = ppl_pkg::MODE_IDLE;
        endcase
    endfunction

    assign go = reg_wr && reg_addr == ppl_pkg::REG_CTRL && reg_wdata[ppl_pkg::CTRL_GO_BIT] &&
                en_r && state_r == ST_IDLE;
    assign is_write = (op_r != ppl_pkg::PPL_OP_VERIFY) && (op_r != ppl_pkg::PPL_OP_VERIFY_EXP) &&
                      (op_r != ppl_pkg::PPL_OP_VERIFY_CFG);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            en_r      <= 1'b0;
            ctrl_op_r <= ppl_pkg::PPL_OP_PROG;
            addr_r    <= 15'h0000;
            data_r    <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == ppl_pkg::REG_CTRL) begin
                en_r      <= reg_wdata[ppl_pkg::CTRL_EN_BIT];
                ctrl_op_r <= ppl_pkg::ppl_op_t'(reg_wdata[ppl_pkg::CTRL_OP_LSB +: 3]);
            end else if (reg_addr == ppl_pkg::REG_ADDR) begin
                addr_r <= reg_wdata[14:0];
            end else if (reg_addr == ppl_pkg::REG_DATA) begin
                data_r <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 16'h0000;
        end else if (!reg_rd) begin
            rdata_r <= 16'h0000;
        end else if (reg_addr == ppl_pkg::REG_CTRL) begin
            rdata_r <= {11'h000, 1'b0, 1'(ctrl_op_r >> 2), 2'(ctrl_op_r), en_r};
        end else if (reg_addr == ppl_pkg::REG_ADDR) begin
            rdata_r <= {1'b0, addr_r};
        end else if (reg_addr == ppl_pkg::REG_DATA) begin
            rdata_r <= {8'h00, data_r};
        end else if (reg_addr == ppl_pkg::REG_STATUS) begin
            rdata_r <= {rd_byte_r, 6'h00, done_r, state_r != ST_IDLE};
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    // read-back crosses from the device: two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            din1_r <= 8'hFF;
            din2_r <= 8'hFF;
        end else begin
            din1_r <= link.port0_level;
            din2_r <= din1_r;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r    <= ST_IDLE;
            cnt_r      <= '0;
            op_r       <= ppl_pkg::PPL_OP_PROG;
            done_r     <= 1'b0;
            rd_byte_r  <= 8'h00;
            pulse_n_r  <= 1'b1;
            hv_r       <= 1'b0;
            mode_r     <= ppl_pkg::MODE_IDLE;
            pin_addr_r <= 15'h0000;
            dout_r     <= 8'h00;
            doe_r      <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (go && mode_of(ctrl_op_r) != ppl_pkg::MODE_IDLE) begin
                        op_r       <= ctrl_op_r;
                        done_r     <= 1'b0;
                        mode_r     <= mode_of(ctrl_op_r);
                        pin_addr_r <= (ctrl_op_r == ppl_pkg::PPL_OP_PROG_CFG) ? {7'h00, addr_r[7:0]} : addr_r;
                        dout_r     <= data_r;
                        hv_r       <= (ctrl_op_r != ppl_pkg::PPL_OP_VERIFY) &&
                                      (ctrl_op_r != ppl_pkg::PPL_OP_VERIFY_EXP) &&
                                      (ctrl_op_r != ppl_pkg::PPL_OP_VERIFY_CFG);
                        doe_r      <= (ctrl_op_r != ppl_pkg::PPL_OP_VERIFY) &&
                                      (ctrl_op_r != ppl_pkg::PPL_OP_VERIFY_EXP) &&
                                      (ctrl_op_r != ppl_pkg::PPL_OP_VERIFY_CFG);
                        cnt_r      <= CNT_W'(SETUP_CYC > VERIFY_CYC ? SETUP_CYC : VERIFY_CYC);
                        state_r    <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt_r <= cnt_r - CNT_W'(1);
                    if (cnt_r == CNT_W'(1)) begin
                        if (is_write) begin
                            pulse_n_r <= 1'b0;
                            cnt_r     <= CNT_W'(PULSE_CYC);
                            state_r   <= ST_STROBE;
                        end else begin
                            rd_byte_r <= din2_r;
                            mode_r    <= ppl_pkg::MODE_IDLE;
                            done_r    <= 1'b1;
                            state_r   <= ST_IDLE;
                        end
                    end
                end
                ST_STROBE: begin
                    cnt_r <= cnt_r - CNT_W'(1);
                    if (cnt_r == CNT_W'(1)) begin
                        pulse_n_r <= 1'b1;
                        cnt_r     <= CNT_W'(op_r == ppl_pkg::PPL_OP_PROG_EXP ? EXP_RECOVER_CYC : RECOVER_CYC);
                        state_r   <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    cnt_r <= cnt_r - CNT_W'(1);
                    if (cnt_r == CNT_W'(1)) begin
                        doe_r   <= 1'b0;
                        hv_r    <= 1'b0;
                        mode_r  <= ppl_pkg::MODE_IDLE;
                        done_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign link.reset_pin              = en_r;
    assign link.program_fetch_strobe_n = ~en_r;
    assign link.external_access_pin    = en_r;
    assign link.external_access_pin_hv = hv_r;
    assign link.prog_pulse_n           = pulse_n_r;
    assign {link.mode_select_hi, link.mode_select_mid, link.mode_select_lo} = mode_r;
    assign {link.port2_addr, link.port1_addr} = pin_addr_r;
    assign link.prog_data_out          = dout_r;
    assign link.prog_data_oe           = doe_r;
    assign reg_rdata                   = rdata_r;
endmodule
`default_nettype wire

// ---- dv/ppl_link_assertions.sv ----
`default_nettype none
module ppl_link_assertions (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       reset_pin,
    input wire logic       program_fetch_strobe_n,
    input wire logic       prog_pulse_n,
    input wire logic       external_access_pin,
    input wire logic       external_access_pin_hv,
    input wire logic       mode_select_hi,
    input wire logic       mode_select_mid,
    input wire logic       mode_select_lo,
    input wire logic [7:0] port1_addr,
    input wire logic [7:0] prog_data_out,
    input wire logic       prog_data_oe,
    input wire logic       dev_data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [2:0] mode;
    assign mode = {mode_select_hi, mode_select_mid, mode_select_lo};
    sequence s_fall; $fell(prog_pulse_n); endsequence
    sequence s_idle5; (mode == 3'h7)[*5]; endsequence
    property p_len; s_fall |=> !prog_pulse_n[*8] ##1 !prog_pulse_n ##1 prog_pulse_n; endproperty
    property p_qual; !prog_pulse_n |-> reset_pin && !program_fetch_strobe_n && external_access_pin_hv; endproperty
    property p_setup; s_fall |-> $past(external_access_pin_hv, 4) && ($past(mode, 4) == mode); endproperty
    property p_hold; !prog_pulse_n |-> $stable(mode) && $stable(port1_addr) && $stable(prog_data_out); endproperty
    property p_rec; $rose(prog_pulse_n) && mode_select_hi |-> ##14 !prog_data_oe; endproperty
    property p_exp_rec; $rose(prog_pulse_n) && (mode == 3'h2) |-> ##25 prog_data_oe; endproperty
    property p_fight; dev_data_oe |-> !prog_data_oe; endproperty
    property p_vfy; $fell(mode_select_hi) && !mode_select_mid && external_access_pin |-> ##[2:8] dev_data_oe; endproperty
    property p_vexp;
        $fell(mode_select_hi) && (mode == 3'h2) && prog_pulse_n && !external_access_pin_hv |-> ##[2:8] dev_data_oe;
    endproperty
    // the far end stays off the port when no cycle is selected
    property p_quiet; s_idle5 |-> !dev_data_oe; endproperty
    a_len: assert property (p_len) else $error("program pulse length wrong");
    a_qual: assert property (p_qual) else $error("pulse outside load mode");
    a_setup: assert property (p_setup) else $error("pins not set up before pulse");
    a_hold: assert property (p_hold) else $error("pins moved during pulse");
    a_rec: assert property (p_rec) else $error("normal cycle not ended");
    a_exp_rec: assert property (p_exp_rec) else $error("expanded recovery too short");
    a_fight: assert property (p_fight) else $error("data port contention");
    a_vfy: assert property (p_vfy) else $error("verify byte not driven");
    a_vexp: assert property (p_vexp) else $error("expanded verify not driven");
    a_quiet: assert property (p_quiet) else $error("device drives port while idle");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock;
    logic        resetn;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [15:0] rv;
    logic [7:0]  memory_config_reg_o;
    logic [39:0] key_o;
    logic        lock_o;
    logic        busy_o;
    logic        rd_d;
    logic [31:0] expq[$];
    logic [31:0] ent;
    logic [14:0] a;
    logic [7:0]  d;
    logic [7:0]  dk[5];
    int          failures;
    int          n_checks;
    int          n_busy = 0;
    localparam int BUSY_CYC = 20;
    ppl_link_if link ();
    // short commit and recovery keep the run brief; recovery must exceed busy plus sync
    ppl_device #(.EXP_BUSY_CYC(BUSY_CYC)) ppl_device_i (.clock(clock), .resetn(resetn), .link(link),
        .memory_config_reg_o(memory_config_reg_o), .key_o(key_o), .lock_o(lock_o), .busy_o(busy_o));
    ppl_programmer #(.EXP_RECOVER_CYC(30)) ppl_programmer_i (.clock(clock), .resetn(resetn), .link(link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ppl_link_assertions ppl_link_assertions_i (.clock(clock), .resetn(resetn), .reset_pin(link.reset_pin),
        .program_fetch_strobe_n(link.program_fetch_strobe_n), .prog_pulse_n(link.prog_pulse_n),
        .external_access_pin(link.external_access_pin), .external_access_pin_hv(link.external_access_pin_hv),
        .mode_select_hi(link.mode_select_hi), .mode_select_mid(link.mode_select_mid),
        .mode_select_lo(link.mode_select_lo), .port1_addr(link.port1_addr),
        .prog_data_out(link.prog_data_out), .prog_data_oe(link.prog_data_oe), .dev_data_oe(link.dev_data_oe));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic test_done;
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %0t device output %h expected %h", $time, g, e);
            failures++;
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
        @(posedge clock);
        reg_addr  <= ad;
        reg_wdata <= wd;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [15:0] e, input logic [15:0] m);
        @(posedge clock);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        expq.push_back({m, e});
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        rv = reg_rdata;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (busy_o === 1'b1) begin
            n_busy <= n_busy + 1;
        end
        if (rd_d) begin
            ent = expq.pop_front();
            n_checks++;
            if ((reg_rdata & ent[31:16]) !== (ent[15:0] & ent[31:16])) begin
                $display("ERROR %0t read data %h expected %h", $time, reg_rdata, ent[15:0]);
                failures++;
            end
        end
    end
    task automatic op(input logic [2:0] o, input logic [14:0] ad, input logic [7:0] wd);
        wr(ppl_pkg::REG_ADDR, {1'b0, ad});
        wr(ppl_pkg::REG_DATA, {8'h00, wd});
        // go starts the op stored by an earlier write
        wr(ppl_pkg::REG_CTRL, {11'h000, 1'b0, o, 1'b1});
        wr(ppl_pkg::REG_CTRL, {11'h000, 1'b1, o, 1'b1});
        for (int i = 0; i < 3000; i++) begin
            rd(ppl_pkg::REG_STATUS, 16'h0000, 16'h00FC);
            if (rv[1] === 1'b1) break;
            if (i == 2999) begin
                $display("ERROR %0t operation never completed", $time);
                failures++;
                test_done();
            end
        end
        repeat (8) @(posedge clock);
    endtask
    initial begin
        resetn    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        failures  = 0;
        n_checks  = 0;
        void'($urandom(60879));
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        wr(ppl_pkg::REG_CTRL, 16'h0013);
        repeat (40) @(posedge clock);
        rd(ppl_pkg::REG_STATUS, 16'h0000, 16'h0002);
        chk(memory_config_reg_o, ppl_pkg::MEMORY_CONFIG_REG_RESET);
        a = 15'($urandom) & 15'h0FFF;
        d = 8'($urandom);
        op(3'h0, a, d);
        chk(memory_config_reg_o, ppl_pkg::MEMORY_CONFIG_REG_INIT);
        op(3'h2, a, 8'h00);
        rd(ppl_pkg::REG_STATUS, {d, 8'h00}, 16'hFF00);
        for (int k = 0; k < 5; k++) begin
            dk[k] = 8'($urandom);
            op(3'h5, {7'h00, ppl_pkg::KEY_BASE + 8'(k)}, dk[k]);
        end
        for (int k = 0; k < 5; k++) begin
            chk(key_o[8*k +: 8], dk[k]);
        end
        op(3'h5, {7'h01, ppl_pkg::MEMORY_CONFIG_REG_ADDR}, 8'h20);
        chk(memory_config_reg_o, 8'h20);
        a = {2'b10, 13'($urandom)};
        d = 8'($urandom);
        op(3'h3, a, d);
        chk(8'(n_busy), 8'(BUSY_CYC));
        op(3'h4, a, 8'h00);
        rd(ppl_pkg::REG_STATUS, {d, 8'h00}, 16'hFF00);
        op(3'h6, {7'h00, ppl_pkg::MEMORY_CONFIG_REG_ADDR}, 8'h00);
        rd(ppl_pkg::REG_STATUS, {8'h20, 8'h00}, 16'hFF00);
        op(3'h5, {7'h00, ppl_pkg::MEMORY_CONFIG_REG_ADDR}, 8'h11);
        chk({7'h00, lock_o}, 8'h01);
        resetn <= 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        chk(memory_config_reg_o, ppl_pkg::MEMORY_CONFIG_REG_RESET);
        wr(ppl_pkg::REG_CTRL, 16'h0001);
        op(3'h1, 15'h0000, 8'h00);
        chk(memory_config_reg_o, ppl_pkg::MEMORY_CONFIG_REG_INIT | 8'h01);
        wr(ppl_pkg::REG_CTRL, 16'h000F);
        wr(ppl_pkg::REG_CTRL, 16'h001F);
        rd(ppl_pkg::REG_CTRL, 16'h000F, 16'hFFFF);
        rd(ppl_pkg::REG_STATUS, 16'h0000, 16'h0001);
        rd(4'hF, 16'h0000, 16'hFFFF);
        repeat (2) @(posedge clock);
        test_done();
    end
endmodule
`default_nettype wire
